// >>> design/awis_pkg.sv
// Package for the converter window detector and input select block.
// Assumes an 8-bit special function register bus driven by the CPU core.
package awis_pkg;

  localparam int unsigned SFR_AW    = 8;
  localparam int unsigned SFR_DW    = 8;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned RES_W     = 10;
  localparam int unsigned SEL_W     = 5;
  localparam int unsigned PIN_N     = 16;

  // Register addresses
  localparam logic [7:0] ADDR_TEMP_OFFSET_VALUE_LOW   = 8'h85;
  localparam logic [7:0] ADDR_TEMP_OFFSET_VALUE_HIGH  = 8'h86;
  localparam logic [7:0] ADDR_INPUT_SEL  = 8'hbb;
  localparam logic [7:0] ADDR_UPPER_LOW  = 8'hc3;
  localparam logic [7:0] ADDR_UPPER_HIGH = 8'hc4;
  localparam logic [7:0] ADDR_LOWER_LOW  = 8'hc5;
  localparam logic [7:0] ADDR_LOWER_HIGH = 8'hc6;
  localparam logic [7:0] ADDR_CONV_CTRL  = 8'he8;

  // Reset values
  localparam logic [7:0] RST_UPPER       = 8'hff;
  localparam logic [7:0] RST_LOWER       = 8'h00;
  localparam logic [4:0] RST_INPUT_SEL   = 5'h1f;
  localparam logic [7:0] RST_CONV_CTRL   = 8'h00;

  // Converter control fields
  localparam int unsigned CTRL_OUTSIDE_BIT = 0;
  localparam int unsigned CTRL_FLAG_BIT    = 3;

  // Temperature offset low byte fields
  localparam int unsigned TEMP_OFFSET_VALUE_LOW_MSB = 7;
  localparam int unsigned TEMP_OFFSET_VALUE_LOW_LSB = 6;

  // Input select codes
  localparam logic [4:0] SEL_LAST_PIN = 5'h0f;
  localparam logic [4:0] SEL_TEMP     = 5'h10;
  localparam logic [4:0] SEL_SUPPLY   = 5'h11;

endpackage : awis_pkg

// >>> design/awis_cmp_if.sv
// Interface carrying a conversion word and the limits to the comparator.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface awis_cmp_if;
  import awis_pkg::*;
  logic [WORD_W-1:0] result;
  logic [WORD_W-1:0] lower;
  logic [WORD_W-1:0] upper;
  logic              outside;
  logic              hit;

  modport ctrl (output result, output lower, output upper,
                output outside, input hit);
  modport cmp  (input result, input lower, input upper,
                input outside, output hit);
endinterface : awis_cmp_if
`default_nettype wire

// >>> design/awis_window.sv
// Window comparator: purely combinational match of one conversion word.
// Assumes limits and result share the same justification.
`timescale 1ns/100ps
`default_nettype none
module awis_window
  import awis_pkg::*;
(
  awis_cmp_if.cmp cmp
);

  wire logic above_lower;
  wire logic below_upper;
  wire logic under_lower;
  wire logic over_upper;

  // Unsigned compares on the full justified word
  assign above_lower = cmp.result > cmp.lower;
  assign below_upper = cmp.result < cmp.upper;
  assign under_lower = cmp.result < cmp.lower;
  assign over_upper  = cmp.result > cmp.upper;

  assign cmp.hit = cmp.outside ? (under_lower | over_upper)
                               : (above_lower & below_upper);

endmodule // awis_window
`default_nettype wire

// >>> design/awis_top.sv
// Window detector, positive input select and temperature offset registers.
// Assumes conversion words arrive justified, on clk, with a one-cycle strobe.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Inside mode: lower < result < upper
// - Outside mode: result below lower or above upper
// - Result compared as unsigned word
// - Compare works for either justification
// - Lower limit low byte, RW, reset zero
// - Codes 0-15 route port pins ascending
// - Temp sensor, supply, then no input
// - Select field bits 4:0, upper read-only
// - Disabled temp sensor stays high impedance
// - Offset stored left-justified over two bytes
// - Offset holds per-device production value
// - Match flag in control, polled or interrupt
// - Upper limit high byte RW, resets ones
module awis_top
  import awis_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [SFR_AW-1:0] sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [SFR_DW-1:0] sfr_wdata,
  output logic      [SFR_DW-1:0] sfr_rdata,
  input  wire logic              conv_done,
  input  wire logic [WORD_W-1:0] conv_result,
  input  wire logic              temp_sensor_enable,
  input  wire logic [RES_W-1:0]  factory_offset,
  output logic                   window_match_flag,
  output logic      [PIN_N-1:0]  amux_pin_sel,
  output logic                   amux_temp_sel,
  output logic                   amux_vdd_sel,
  output logic                   temp_sensor_hiz
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0]       upper_limit_high_byte;
  logic [7:0]       upper_limit_low_byte;
  logic [7:0]       lower_limit_high_byte;
  logic [7:0]       lower_limit_low_byte;
  logic [SEL_W-1:0] positive_input_select;
  logic             outside_mode;
  logic [7:0]       temp_offset_high;
  logic [1:0]       temp_offset_low;
  logic             offset_loaded;

  wire logic wr_upper_high;
  wire logic wr_upper_low;
  wire logic wr_lower_high;
  wire logic wr_lower_low;
  wire logic wr_sel;
  wire logic wr_ctrl;
  wire logic wr_temp_offset_value_high;
  wire logic wr_temp_offset_value_low;

  assign wr_upper_high = sfr_wr & (sfr_addr == ADDR_UPPER_HIGH);
  assign wr_upper_low  = sfr_wr & (sfr_addr == ADDR_UPPER_LOW);
  assign wr_lower_high = sfr_wr & (sfr_addr == ADDR_LOWER_HIGH);
  assign wr_lower_low  = sfr_wr & (sfr_addr == ADDR_LOWER_LOW);
  assign wr_sel        = sfr_wr & (sfr_addr == ADDR_INPUT_SEL);
  assign wr_ctrl       = sfr_wr & (sfr_addr == ADDR_CONV_CTRL);
  assign wr_temp_offset_value_high  = sfr_wr & (sfr_addr == ADDR_TEMP_OFFSET_VALUE_HIGH);
  assign wr_temp_offset_value_low   = sfr_wr & (sfr_addr == ADDR_TEMP_OFFSET_VALUE_LOW);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      upper_limit_high_byte <= RST_UPPER;
      upper_limit_low_byte  <= RST_UPPER;
      lower_limit_high_byte <= RST_LOWER;
      lower_limit_low_byte  <= RST_LOWER;
    end else begin
      if (wr_upper_high) upper_limit_high_byte <= sfr_wdata;
      if (wr_upper_low)  upper_limit_low_byte  <= sfr_wdata;
      if (wr_lower_high) lower_limit_high_byte <= sfr_wdata;
      if (wr_lower_low)  lower_limit_low_byte  <= sfr_wdata;
    end
  end

  // Select field and outside-mode bit are stored; select bits 7:5 have no storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      positive_input_select <= RST_INPUT_SEL;
      outside_mode          <= RST_CONV_CTRL[CTRL_OUTSIDE_BIT];
    end else begin
      if (wr_sel) positive_input_select <= sfr_wdata[SEL_W-1:0];
      if (wr_ctrl) outside_mode <= sfr_wdata[CTRL_OUTSIDE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temperature offset: production value caught after reset release

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      offset_loaded    <= 1'b0;
      temp_offset_high <= 8'h00;
      temp_offset_low  <= 2'h0;
    end else if (!offset_loaded) begin
      offset_loaded    <= 1'b1;
      temp_offset_high <= factory_offset[9:2];
      temp_offset_low  <= factory_offset[1:0];
    end else begin
      if (wr_temp_offset_value_high) temp_offset_high <= sfr_wdata;
      if (wr_temp_offset_value_low)
        temp_offset_low <= sfr_wdata[TEMP_OFFSET_VALUE_LOW_MSB:TEMP_OFFSET_VALUE_LOW_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window compare and sticky flag

  awis_cmp_if cmp_bus ();

  assign cmp_bus.result  = conv_result;
  // Greater-than word bounds a hit from below, less-than word from above
  assign cmp_bus.lower   = {upper_limit_high_byte, upper_limit_low_byte};
  assign cmp_bus.upper   = {lower_limit_high_byte, lower_limit_low_byte};
  assign cmp_bus.outside = outside_mode;

  awis_window u_window (
    .cmp (cmp_bus.cmp)
  );

  wire logic match_event;
  wire logic flag_write;
  wire logic next_flag;

  assign match_event = conv_done & cmp_bus.hit;
  assign flag_write  = wr_ctrl;
  // Hardware set wins over a software clear in the same cycle
  assign next_flag   = match_event |
                       (flag_write ? sfr_wdata[CTRL_FLAG_BIT]
                                   : window_match_flag);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) window_match_flag <= RST_CONV_CTRL[CTRL_FLAG_BIT];
    else       window_match_flag <= next_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input multiplexer selects

  wire logic [PIN_N-1:0] next_pin_sel;
  wire logic             next_temp_sel;
  wire logic             next_vdd_sel;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      assign next_pin_sel[gi] =
        (positive_input_select == SEL_W'(gi));
    end
  endgenerate

  assign next_temp_sel = (positive_input_select == SEL_TEMP);
  assign next_vdd_sel  = (positive_input_select == SEL_SUPPLY);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      amux_pin_sel    <= '0;
      amux_temp_sel   <= 1'b0;
      amux_vdd_sel    <= 1'b0;
      temp_sensor_hiz <= 1'b1;
    end else begin
      amux_pin_sel    <= next_pin_sel;
      amux_temp_sel   <= next_temp_sel;
      amux_vdd_sel    <= next_vdd_sel;
      temp_sensor_hiz <= ~temp_sensor_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] read_mux;

  always_comb begin
    read_mux = 8'h00;
    unique case (sfr_addr)
      ADDR_UPPER_HIGH: read_mux = upper_limit_high_byte;
      ADDR_UPPER_LOW:  read_mux = upper_limit_low_byte;
      ADDR_LOWER_HIGH: read_mux = lower_limit_high_byte;
      ADDR_LOWER_LOW:  read_mux = lower_limit_low_byte;
      ADDR_INPUT_SEL:  read_mux = {3'h0, positive_input_select};
      ADDR_CONV_CTRL:  read_mux = {4'h0, window_match_flag, 2'h0,
                                   outside_mode};
      ADDR_TEMP_OFFSET_VALUE_HIGH:  read_mux = temp_offset_high;
      ADDR_TEMP_OFFSET_VALUE_LOW:   read_mux = {temp_offset_low, 6'h00};
      default:         read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)       sfr_rdata <= 8'h00;
    else if (sfr_rd) sfr_rdata <= read_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence seq_conv_in;
    !outside_mode && conv_done &&
      cmp_bus.lower < conv_result && conv_result < cmp_bus.upper;
  endsequence

  sequence seq_conv_out;
    outside_mode && conv_done && (conv_result < cmp_bus.lower ||
                                  conv_result > cmp_bus.upper);
  endsequence

  sequence seq_sel_read;
    sfr_rd && sfr_addr == ADDR_INPUT_SEL;
  endsequence

  chk_inside_sets_flag: assert property (
    @(posedge clk) disable iff (!nrst)
    seq_conv_in |=> window_match_flag)
    else $error("inside match did not set flag");

  chk_outside_sets_flag: assert property (
    @(posedge clk) disable iff (!nrst)
    seq_conv_out |=> window_match_flag)
    else $error("outside match did not set flag");

  chk_flag_no_cause: assert property (
    @(posedge clk) disable iff (!nrst)
    (!window_match_flag && !conv_done && !wr_ctrl) |=> !window_match_flag)
    else $error("flag set without a conversion");

  chk_flag_sticky: assert property (
    @(posedge clk) disable iff (!nrst)
    (window_match_flag && !wr_ctrl) |=> window_match_flag)
    else $error("flag dropped without clear");

  chk_lower_low_read: assert property (
    @(posedge clk) disable iff (!nrst)
    (sfr_rd && sfr_addr == ADDR_LOWER_LOW)
      |=> sfr_rdata == $past(lower_limit_low_byte))
    else $error("lower limit low byte read wrong");

  chk_sel_read_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    seq_sel_read |=> sfr_rdata[7:5] == 3'h0 &&
      sfr_rdata[4:0] == $past(positive_input_select))
    else $error("select register read wrong");

  chk_pin_route: assert property (
    @(posedge clk) disable iff (!nrst)
    (positive_input_select <= SEL_LAST_PIN) |=>
      amux_pin_sel == (16'h0001 << $past(positive_input_select[3:0])))
    else $error("port pin route wrong");

  chk_special_route: assert property (
    @(posedge clk) disable iff (!nrst)
    (positive_input_select > SEL_LAST_PIN) |=>
      amux_pin_sel == 16'h0000 &&
      amux_temp_sel == ($past(positive_input_select) == SEL_TEMP) &&
      amux_vdd_sel == ($past(positive_input_select) == SEL_SUPPLY))
    else $error("special input route wrong");

  chk_sensor_hiz: assert property (
    @(posedge clk) disable iff (!nrst)
    !temp_sensor_enable ##1 !temp_sensor_enable |-> temp_sensor_hiz)
    else $error("disabled sensor not high impedance");

  chk_offset_capture: assert property (
    @(posedge clk) disable iff (!nrst)
    !offset_loaded |=> {temp_offset_high, temp_offset_low} ==
      $past(factory_offset))
    else $error("offset not captured left-justified");

  chk_upper_reset: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(offset_loaded) && !$past(wr_upper_high) |->
      upper_limit_high_byte == RST_UPPER)
    else $error("upper limit high byte reset wrong");

  chk_flag_clear: assert property (
    @(posedge clk) disable iff (!nrst)
    (window_match_flag && wr_ctrl && !sfr_wdata[CTRL_FLAG_BIT] &&
     !conv_done) |=> !window_match_flag)
    else $error("flag not cleared by software write");

  chk_offset_low_read: assert property (
    @(posedge clk) disable iff (!nrst)
    (sfr_rd && sfr_addr == ADDR_TEMP_OFFSET_VALUE_LOW) |=>
      sfr_rdata == {$past(temp_offset_low), 6'h00})
    else $error("offset low byte read wrong");

  chk_ctrl_flag_read: assert property (
    @(posedge clk) disable iff (!nrst)
    (sfr_rd && sfr_addr == ADDR_CONV_CTRL) |=>
      sfr_rdata[CTRL_FLAG_BIT] == $past(window_match_flag))
    else $error("control read does not show flag");

endmodule // awis_top
`default_nettype wire

// >>> verif/awis_cpu_model.sv
// CPU core model issuing special function register writes and reads.
// Assumes the bench calls its tasks; it steps on falling edges of clk.
`timescale 1ns/100ps
`default_nettype none
module awis_cpu_model
  import awis_pkg::*;
(
  input  wire logic              clk,
  output logic      [SFR_AW-1:0] sfr_addr,
  output logic                   sfr_wr,
  output logic                   sfr_rd,
  output logic      [SFR_DW-1:0] sfr_wdata,
  input  wire logic [SFR_DW-1:0] sfr_rdata
);
  initial begin
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_wdata = 8'h00;
  end

  // One-cycle strobe, taken at the rising edge in between
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr    = 1'b0;
    sfr_wdata = ~d;
  endtask

  // Read data lands on the edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd   = 1'b0;
    sfr_addr = ~a;
    d        = sfr_rdata;
  endtask
endmodule // awis_cpu_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the window detector and input select block.
// Assumes the CPU model drives the register bus; bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import awis_pkg::*;
  logic              clk = 1'b0;
  logic              nrst;
  logic [SFR_AW-1:0] sfr_addr;
  logic              sfr_wr, sfr_rd;
  logic [SFR_DW-1:0] sfr_wdata, sfr_rdata;
  logic              conv_done, temp_sensor_enable;
  logic [WORD_W-1:0] conv_result;
  logic [RES_W-1:0]  factory_offset;
  logic              window_match_flag, amux_temp_sel, amux_vdd_sel;
  logic              temp_sensor_hiz;
  logic [PIN_N-1:0]  amux_pin_sel;
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                cycles     = 0;
  logic [15:0]       res_r [6] = '{16'h003f, 16'h0040, 16'h0041,
                                   16'h007f, 16'h0080, 16'h0081};
  logic [15:0]       res_l [6] = '{16'h0fc0, 16'h1000, 16'h1040,
                                   16'h1fc0, 16'h2000, 16'h2040};

  always #20 clk = ~clk;

  awis_cpu_model cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

  awis_top dut (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .conv_done(conv_done),
    .conv_result(conv_result), .temp_sensor_enable(temp_sensor_enable),
    .factory_offset(factory_offset), .window_match_flag(window_match_flag),
    .amux_pin_sel(amux_pin_sel), .amux_temp_sel(amux_temp_sel),
    .amux_vdd_sel(amux_vdd_sel), .temp_sensor_hiz(temp_sensor_hiz));

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: output %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpu.rd(a, d);
    n_compared++;
    if (d !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: read %h gave %h, wanted %h",
               $time, a, d, exp);
    end
  endtask

  // lo is the less-than word, hi the greater-than word
  task automatic lim(input logic [15:0] lo, input logic [15:0] hi);
    cpu.wr(ADDR_LOWER_HIGH, lo[15:8]);
    cpu.wr(ADDR_LOWER_LOW, lo[7:0]);
    cpu.wr(ADDR_UPPER_HIGH, hi[15:8]);
    cpu.wr(ADDR_UPPER_LOW, hi[7:0]);
  endtask

  // Optionally clear the flag and set the mode, then one conversion
  task automatic conv(input logic o, input logic [15:0] r, input logic clr);
    if (clr) cpu.wr(ADDR_CONV_CTRL, {7'h00, o});
    @(negedge clk);
    conv_done   = 1'b1;
    conv_result = r;
    @(negedge clk);
    conv_done   = 1'b0;
    conv_result = ~r;
  endtask

  function automatic logic exp_flag(input logic o, input logic [15:0] r,
                                    input logic [15:0] lt, gt);
    return o ? (r < gt || r > lt) : (r > gt && r < lt);
  endfunction

  task automatic sweep(input logic [15:0] lo, hi, input logic [15:0] rs[6]);
    lim(lo, hi);
    foreach (rs[i]) begin
      for (int o = 0; o < 2; o++) begin
        conv(o[0], rs[i], 1'b1);
        chk_out({15'h0, window_match_flag}, {15'h0, exp_flag(o[0], rs[i], lo, hi)});
      end
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    nrst               = 1'b0;
    conv_done          = 1'b0;
    conv_result        = 16'h0000;
    temp_sensor_enable = 1'b0;
    factory_offset     = 10'h2b5;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    rchk(ADDR_TEMP_OFFSET_VALUE_HIGH, 8'had);
    rchk(ADDR_TEMP_OFFSET_VALUE_LOW, 8'h40);
    rchk(ADDR_LOWER_LOW, 8'h00);
    rchk(ADDR_LOWER_HIGH, 8'h00);
    rchk(ADDR_UPPER_HIGH, 8'hff);
    rchk(ADDR_UPPER_LOW, 8'hff);
    rchk(ADDR_INPUT_SEL, 8'h1f);
    rchk(ADDR_CONV_CTRL, 8'h00);
    chk_out({amux_pin_sel | {15'h0, amux_temp_sel | amux_vdd_sel}}, 16'h0);
    chk_out({15'h0, temp_sensor_hiz}, 16'h0001);
    temp_sensor_enable = 1'b1;
    @(negedge clk);
    chk_out({15'h0, temp_sensor_hiz}, 16'h0000);
    cpu.wr(ADDR_LOWER_LOW, 8'h5a);
    rchk(ADDR_LOWER_LOW, 8'h5a);
    cpu.wr(ADDR_TEMP_OFFSET_VALUE_LOW, 8'hff);
    rchk(ADDR_TEMP_OFFSET_VALUE_LOW, 8'hc0);
    cpu.wr(8'h00, 8'h77);
    rchk(8'h00, 8'h00);
    for (int c = 0; c < 32; c++) begin
      cpu.wr(ADDR_INPUT_SEL, c[7:0]);
      @(negedge clk);
      chk_out(amux_pin_sel, (c < 16) ? 16'h0001 << c : 16'h0000);
      chk_out({14'h0, amux_temp_sel, amux_vdd_sel}, {14'h0, c == 16, c == 17});
    end
    cpu.wr(ADDR_INPUT_SEL, 8'hf0);
    rchk(ADDR_INPUT_SEL, 8'h10);
    sweep(16'h0080, 16'h0040, res_r);
    sweep(16'h2000, 16'h1000, res_l);
    lim(16'hffff, 16'h1000);
    conv(1'b0, 16'hffc0, 1'b1);
    chk_out({15'h0, window_match_flag}, 16'h0001);
    conv(1'b0, 16'h0000, 1'b0);
    chk_out({15'h0, window_match_flag}, 16'h0001);
    rchk(ADDR_CONV_CTRL, 8'h08);
    cpu.wr(ADDR_CONV_CTRL, 8'h00);
    @(negedge clk);
    chk_out({15'h0, window_match_flag}, 16'h0000);
    // Match and clear in one cycle: the match wins
    fork
      cpu.wr(ADDR_CONV_CTRL, 8'h00);
      conv(1'b0, 16'h8000, 1'b0);
    join
    chk_out({15'h0, window_match_flag}, 16'h0001);
    wrap_up;
  end
endmodule // tb
`default_nettype wire
